// [rtl/cpu_dsp_register_file.sv]
// cpu register file with dsp addressing extension, banked low registers,
// control and system registers and x/y/single pointer generation.
// assumes the pipeline drives one-cycle strobes on clk_sys and never
// asks for two conflicting updates of one register in the same cycle.
//
// Notes on behaviour
// [RULE1] bank-select one: bank one is general
// [RULE2] bank-select zero: bank zero is general
// [RULE3] status word reset value fixed
// [RULE4] reset loads counter, clears vector base, dsp status
// [RULE5] sixteen 32-bit general registers
// [RULE6] register zero serves as index register
// [RULE7] x pointer r4/r5, x index r8
// [RULE8] y pointer r6/r7, y index r9
// [RULE9] single pointer r2..r5, index r8
// [RULE10] dsp addressing only with dsp bit set
// [RULE11] circular enables select x or y
// [RULE12] both enables set: only y circular
// [RULE13] single transfers never circular
// [RULE14] repeat-step encoding of loop length
// [RULE15] setup instruction or status write sets repeat
// [RULE16] twelve-bit repeat counter in status word
// [RULE17] bounds register: end high, start low
// [RULE18] pointer equal to end reloads start
// [RULE19] post-increment four, pre-decrement four
// [RULE20] loop pointers load displacement times two plus counter
// [RULE21] exception saves status word and counter
// [RULE22] dsp status and data registers reachable
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cpu_dsp_register_file
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] rd_a_addr,
	input wire logic [3:0] rd_b_addr,
	output logic [31:0] rd_a_q,
	output logic [31:0] rd_b_q,
	output logic [31:0] index_r0_q,
	input wire logic gw_en,
	input wire logic [3:0] gw_addr,
	input wire logic [31:0] gw_data,
	input wire logic [4:0] cr_addr,
	input wire logic [31:0] cr_wdata,
	input wire logic cr_wr,
	input wire logic cr_rd,
	output logic [31:0] cr_rdata_q,
	input wire logic pc_we,
	input wire logic [31:0] pc_wdata,
	output logic [31:0] pc_out,
	input wire logic exc_en,
	input wire logic repeat_setup_instr_en,
	input wire logic [11:0] repeat_setup_instr_count,
	input wire logic [2:0] repeat_setup_instr_len,
	input wire logic rc_dec,
	input wire logic loop_start_set_instr_en,
	input wire logic loop_end_set_instr_en,
	input wire logic [7:0] loop_disp,
	input wire logic mp_en,
	input wire logic mp_dec,
	input wire logic [3:0] mp_reg,
	output logic [31:0] mp_addr_q,
	input wire logic agx_en,
	input wire logic agx_sel,
	input wire logic agx_idx,
	output logic [31:0] x_addr_q,
	input wire logic agy_en,
	input wire logic agy_sel,
	input wire logic agy_idx,
	output logic [31:0] y_addr_q,
	input wire logic ags_en,
	input wire logic [1:0] ags_sel,
	input wire logic ags_idx,
	output logic [31:0] s_addr_q,
	output logic dsp_mode,
	output logic [11:0] repeat_count,
	output logic [1:0] repeat_steps
);
	// ************************************************************
	// storage
	// ************************************************************
	logic [31:0] bank0_q [8];
	logic [31:0] bank1_q [8];
	logic [31:0] hi_q [8];
	logic [31:0] bank0_d [8];
	logic [31:0] bank1_d [8];
	logic [31:0] hi_d [8];
	logic [31:0] view [16];
	logic [31:0] view_d [16];
	logic [31:0] alt [8];
	logic [31:0] alt_d [8];
	logic [31:0] sr_q, sr_d, ssr_q, ssr_d, spc_q, spc_d, gbr_q, gbr_d;
	logic [31:0] vbr_q, vbr_d, rs_q, rs_d, re_q, re_d, mod_q, mod_d;
	logic [31:0] multiply_acc_high_q, multiply_acc_high_d, multiply_acc_low_q, multiply_acc_low_d, pr_q, pr_d, pc_q, pc_d;
	logic [31:0] a0_q, a0_d, x0_q, x0_d, x1_q, x1_d, y0_q, y0_d, y1_q, y1_d;
	logic [7:0] dsr_q, dsr_d;
	logic [31:0] cr_view;

	function automatic logic [1:0] step_code(input logic [2:0] len);
		logic [1:0] c;
		c = rf_pkg::RF_MORE;
		if (len <= 3'h1)
			c = rf_pkg::RF_ONE;
		else if (len == 3'h2)
			c = rf_pkg::RF_TWO;
		else if (len == 3'h3)
			c = rf_pkg::RF_THREE;
		return c;
	endfunction

	// ************************************************************
	// bank view
	// ************************************************************
	wire rb = sr_q[rf_pkg::SR_RB];
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_bank
			assign view[g] = rb ? bank1_q[g] : bank0_q[g]; // RULE1 RULE2
			assign alt[g] = rb ? bank0_q[g] : bank1_q[g]; // RULE1 RULE2
			assign view[g + 8] = hi_q[g];
			assign bank1_d[g] = rb ? view_d[g] : alt_d[g];
			assign bank0_d[g] = rb ? alt_d[g] : view_d[g];
			assign hi_d[g] = view_d[g + 8];
		end
	endgenerate

	// ************************************************************
	// address generation
	// ************************************************************
	wire dsp = sr_q[rf_pkg::SR_DSP];
	wire x_circular_enable = sr_q[rf_pkg::SR_DMX];
	wire y_circular_enable = sr_q[rf_pkg::SR_DMY];
	wire [15:0] cend = mod_q[31:16]; // RULE17
	wire [15:0] cstart = mod_q[15:0]; // RULE17
	wire x_circ = x_circular_enable && !y_circular_enable; // RULE11 RULE12
	wire y_circ = y_circular_enable; // RULE11 RULE12
	wire [3:0] x_reg = rf_pkg::R_AX0 + {3'h0, agx_sel}; // RULE7
	wire [3:0] y_reg = rf_pkg::R_AY0 + {3'h0, agy_sel}; // RULE8
	wire [3:0] s_reg = rf_pkg::R_AS0 + {2'h0, ags_sel}; // RULE9
	wire [31:0] x_ptr = view[x_reg];
	wire [31:0] y_ptr = view[y_reg];
	wire [31:0] s_ptr = view[s_reg];
	wire [31:0] x_inc = x_ptr + (agx_idx ? view[rf_pkg::R_IX] : rf_pkg::AG_STEP); // RULE7
	wire [31:0] y_inc = y_ptr + (agy_idx ? view[rf_pkg::R_IY] : rf_pkg::AG_STEP); // RULE8
	wire [31:0] s_next = s_ptr + (ags_idx ? view[rf_pkg::R_IX] : rf_pkg::AG_STEP); // RULE9 RULE13
	wire x_wrap = x_circ && x_ptr[15:0] == cend; // RULE18
	wire y_wrap = y_circ && y_ptr[15:0] == cend; // RULE18
	wire [31:0] x_next = x_wrap ? {x_ptr[31:16], cstart} : x_inc; // RULE18
	wire [31:0] y_next = y_wrap ? {y_ptr[31:16], cstart} : y_inc; // RULE18
	wire x_go = agx_en && dsp; // RULE10
	wire y_go = agy_en && dsp; // RULE10
	wire s_go = ags_en && dsp; // RULE10
	wire [31:0] mp_val = view[mp_reg];
	wire [31:0] mp_up = mp_val + rf_pkg::CTL_STEP; // RULE19
	wire [31:0] mp_dn = mp_val - rf_pkg::CTL_STEP; // RULE19
	wire [31:0] loop_addr = pc_q + {{23{loop_disp[7]}}, loop_disp, 1'b0}; // RULE20
	wire alt_wr = cr_wr && cr_addr[4:3] == rf_pkg::CR_ALT_TAG;
	wire [31:0] sr_wval = (cr_wdata & rf_pkg::SR_WMASK) | rf_pkg::SR_FIXED;
	wire [11:0] rc_cur = sr_q[rf_pkg::SR_RC_HI:rf_pkg::SR_RC_LO];

	// ************************************************************
	// general register next values
	// ************************************************************
	always_comb
	begin
		for (int i = 0; i < 16; i++)
			view_d[i] = view[i];
		for (int i = 0; i < 8; i++)
			alt_d[i] = alt[i];
		if (s_go)
			view_d[s_reg] = s_next; // RULE9 RULE13
		if (x_go)
			view_d[x_reg] = x_next; // RULE7 RULE11
		if (y_go)
			view_d[y_reg] = y_next; // RULE8 RULE11
		if (mp_en)
			view_d[mp_reg] = mp_dec ? mp_dn : mp_up; // RULE19
		if (gw_en)
			view_d[gw_addr] = gw_data; // RULE5
		if (alt_wr)
			alt_d[cr_addr[2:0]] = cr_wdata; // RULE1 RULE2
	end

	// ************************************************************
	// control and system register next values
	// ************************************************************
	always_comb
	begin
		sr_d = sr_q;
		ssr_d = exc_en ? sr_q : ssr_q; // RULE21
		spc_d = exc_en ? pc_q : spc_q; // RULE21
		gbr_d = gbr_q;
		vbr_d = vbr_q;
		rs_d = loop_start_set_instr_en ? loop_addr : rs_q; // RULE20
		re_d = loop_end_set_instr_en ? loop_addr : re_q; // RULE20
		mod_d = mod_q;
		multiply_acc_high_d = multiply_acc_high_q;
		multiply_acc_low_d = multiply_acc_low_q;
		pr_d = pr_q;
		pc_d = pc_we ? pc_wdata : pc_q;
		dsr_d = dsr_q;
		a0_d = a0_q;
		x0_d = x0_q;
		x1_d = x1_q;
		y0_d = y0_q;
		y1_d = y1_q;
		if (rc_dec)
			sr_d[rf_pkg::SR_RC_HI:rf_pkg::SR_RC_LO] = rc_cur - 12'h001; // RULE16
		if (repeat_setup_instr_en)
		begin
			sr_d[rf_pkg::SR_RC_HI:rf_pkg::SR_RC_LO] = repeat_setup_instr_count; // RULE15 RULE16
			sr_d[rf_pkg::SR_RF_HI:rf_pkg::SR_RF_LO] = step_code(repeat_setup_instr_len); // RULE14 RULE15
		end
		if (cr_wr)
		begin
			unique case (cr_addr)
				rf_pkg::CR_SR: sr_d = sr_wval; // RULE15
				rf_pkg::CR_SSR: ssr_d = cr_wdata;
				rf_pkg::CR_SPC: spc_d = cr_wdata;
				rf_pkg::CR_GBR: gbr_d = cr_wdata;
				rf_pkg::CR_VBR: vbr_d = cr_wdata;
				rf_pkg::CR_RS: rs_d = cr_wdata;
				rf_pkg::CR_RE: re_d = cr_wdata;
				rf_pkg::CR_MOD: mod_d = cr_wdata; // RULE17
				rf_pkg::CR_MULTIPLY_ACC_HIGH: multiply_acc_high_d = cr_wdata;
				rf_pkg::CR_MULTIPLY_ACC_LOW: multiply_acc_low_d = cr_wdata;
				rf_pkg::CR_PR: pr_d = cr_wdata;
				rf_pkg::CR_PC: pc_d = cr_wdata;
				rf_pkg::CR_DSR: dsr_d = cr_wdata[7:0]; // RULE22
				rf_pkg::CR_A0: a0_d = cr_wdata; // RULE22
				rf_pkg::CR_X0: x0_d = cr_wdata; // RULE22
				rf_pkg::CR_X1: x1_d = cr_wdata; // RULE22
				rf_pkg::CR_Y0: y0_d = cr_wdata; // RULE22
				rf_pkg::CR_Y1: y1_d = cr_wdata; // RULE22
				default: ;
			endcase
		end
	end

	// ************************************************************
	// control port read decode
	// ************************************************************
	always_comb
	begin
		cr_view = rf_pkg::ZERO_WORD;
		if (cr_addr[4:3] == rf_pkg::CR_ALT_TAG)
			cr_view = alt[cr_addr[2:0]]; // RULE1 RULE2
		else
		begin
			unique case (cr_addr)
				rf_pkg::CR_SR: cr_view = sr_q;
				rf_pkg::CR_SSR: cr_view = ssr_q;
				rf_pkg::CR_SPC: cr_view = spc_q;
				rf_pkg::CR_GBR: cr_view = gbr_q;
				rf_pkg::CR_VBR: cr_view = vbr_q;
				rf_pkg::CR_RS: cr_view = rs_q;
				rf_pkg::CR_RE: cr_view = re_q;
				rf_pkg::CR_MOD: cr_view = mod_q;
				rf_pkg::CR_MULTIPLY_ACC_HIGH: cr_view = multiply_acc_high_q;
				rf_pkg::CR_MULTIPLY_ACC_LOW: cr_view = multiply_acc_low_q;
				rf_pkg::CR_PR: cr_view = pr_q;
				rf_pkg::CR_PC: cr_view = pc_q;
				rf_pkg::CR_DSR: cr_view = {24'h000000, dsr_q}; // RULE22
				rf_pkg::CR_A0: cr_view = a0_q;
				rf_pkg::CR_X0: cr_view = x0_q;
				rf_pkg::CR_X1: cr_view = x1_q;
				rf_pkg::CR_Y0: cr_view = y0_q;
				rf_pkg::CR_Y1: cr_view = y1_q;
				default: cr_view = rf_pkg::ZERO_WORD;
			endcase
		end
	end

	// ************************************************************
	// flip-flops
	// ************************************************************
	// general registers carry no reset: they are undefined after reset
	always_ff @(posedge clk_sys)
	begin
		bank0_q <= bank0_d;
		bank1_q <= bank1_d;
		hi_q <= hi_d;
		ssr_q <= ssr_d;
		spc_q <= spc_d;
		gbr_q <= gbr_d;
		rs_q <= rs_d;
		re_q <= re_d;
		mod_q <= mod_d;
		multiply_acc_high_q <= multiply_acc_high_d;
		multiply_acc_low_q <= multiply_acc_low_d;
		pr_q <= pr_d;
		a0_q <= a0_d;
		x0_q <= x0_d;
		x1_q <= x1_d;
		y0_q <= y0_d;
		y1_q <= y1_d;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sr_q <= rf_pkg::SR_RESET; // RULE3
			pc_q <= rf_pkg::PC_RESET; // RULE4
			vbr_q <= rf_pkg::VBR_RESET; // RULE4
			dsr_q <= rf_pkg::DSR_RESET; // RULE4
		end
		else
		begin
			sr_q <= sr_d;
			pc_q <= pc_d;
			vbr_q <= vbr_d;
			dsr_q <= dsr_d;
		end
	end

	// read and address outputs are zeroed by reset so they are not unknown while reset is held
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rd_a_q <= rf_pkg::ZERO_WORD;
			rd_b_q <= rf_pkg::ZERO_WORD;
			index_r0_q <= rf_pkg::ZERO_WORD;
			cr_rdata_q <= rf_pkg::ZERO_WORD;
			mp_addr_q <= rf_pkg::ZERO_WORD;
			x_addr_q <= rf_pkg::ZERO_WORD;
			y_addr_q <= rf_pkg::ZERO_WORD;
			s_addr_q <= rf_pkg::ZERO_WORD;
		end
		else
		begin
			rd_a_q <= view[rd_a_addr]; // RULE5
			rd_b_q <= view[rd_b_addr]; // RULE5
			index_r0_q <= view[0]; // RULE6
			cr_rdata_q <= cr_rd ? cr_view : rf_pkg::ZERO_WORD;
			mp_addr_q <= mp_en ? (mp_dec ? mp_dn : mp_val) : mp_addr_q; // RULE19
			x_addr_q <= x_go ? x_ptr : x_addr_q; // RULE7
			y_addr_q <= y_go ? y_ptr : y_addr_q; // RULE8
			s_addr_q <= s_go ? s_ptr : s_addr_q; // RULE9
		end
	end

	assign pc_out = pc_q;
	assign dsp_mode = dsp; // RULE10
	assign repeat_count = rc_cur; // RULE16
	assign repeat_steps = sr_q[rf_pkg::SR_RF_HI:rf_pkg::SR_RF_LO]; // RULE14

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_exc;
		exc_en && !rst;
	endsequence
	sequence s_y_wrap;
		y_go && y_wrap && !gw_en && !mp_en && !s_go;
	endsequence

	a_reset_sr: assert property (@(posedge clk_sys) rst |=> sr_q == rf_pkg::SR_RESET) // RULE3
		else $error("status word reset value wrong");
	a_reset_ctr: assert property (@(posedge clk_sys) rst |=> pc_q == rf_pkg::PC_RESET // RULE4
		&& vbr_q == rf_pkg::VBR_RESET && dsr_q == rf_pkg::DSR_RESET)
		else $error("counter or vector base reset wrong");
	// general registers carry no reset, so identity is used to let two equal unknowns agree
	a_bank_one: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
		rb && !rd_a_addr[3] |=> rd_a_q === $past(bank1_q[rd_a_addr[2:0]]))
		else $error("bank one not mapped as general");
	a_bank_zero: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
		!rb && !rd_a_addr[3] |=> rd_a_q === $past(bank0_q[rd_a_addr[2:0]]))
		else $error("bank zero not mapped as general");
	a_exc_save: assert property (@(posedge clk_sys) disable iff (rst) // RULE21
		s_exc and !cr_wr |=> ssr_q == $past(sr_q) && spc_q == $past(pc_q))
		else $error("exception did not save state");
	a_y_reload: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
		s_y_wrap |=> view[$past(y_reg)][15:0] == $past(cstart))
		else $error("y pointer not reloaded at end");
	a_both_circ: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		x_circular_enable && y_circular_enable && x_go && !gw_en && !mp_en && !s_go && !y_go
		|=> view[$past(x_reg)] == $past(x_inc))
		else $error("x pointer circular with both enables");
	a_no_dsp: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
		!dsp && agx_en && !gw_en && !mp_en |=> view[$past(x_reg)] == $past(x_ptr))
		else $error("pointer moved outside dsp mode");
	a_repeat_setup_instr_steps: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
		repeat_setup_instr_en && !cr_wr && repeat_setup_instr_len == 3'h3
		|=> repeat_steps == rf_pkg::RF_THREE ##0 repeat_count == $past(repeat_setup_instr_count))
		else $error("repeat setup encoding wrong");
	a_loop_start: assert property (@(posedge clk_sys) disable iff (rst) // RULE20
		loop_start_set_instr_en && !cr_wr |=> rs_q == $past(pc_q) + {{23{$past(loop_disp[7])}}, $past(loop_disp), 1'b0})
		else $error("loop start address wrong");
	a_post_inc: assert property (@(posedge clk_sys) disable iff (rst) // RULE19
		mp_en && !mp_dec && !gw_en && !x_go && !y_go && !s_go
		|=> mp_addr_q == $past(mp_val) && view[$past(mp_reg)] == $past(mp_val) + rf_pkg::CTL_STEP)
		else $error("post-increment wrong");
endmodule
`default_nettype wire

// [rtl/rf_pkg.sv]
// constants for the cpu register file: status word layout, reset values,
// control-port register indices and address-generation steps.
// assumes a single 100 MHz core clock and a synchronous reset.
package rf_pkg;
	// ************************************************************
	// status word fields
	// ************************************************************
	localparam int SR_RF_LO = 2;
	localparam int SR_RF_HI = 3;
	localparam int SR_IM_LO = 4;
	localparam int SR_IM_HI = 7;
	localparam int SR_DMX = 10;
	localparam int SR_DMY = 11;
	localparam int SR_DSP = 12;
	localparam int SR_RC_LO = 16;
	localparam int SR_RC_HI = 27;
	localparam int SR_BL = 28;
	localparam int SR_RB = 29;
	localparam logic [31:0] SR_RESET = 32'h700000F0;
	localparam logic [31:0] SR_WMASK = 32'h3FFF1FFF;
	localparam logic [31:0] SR_FIXED = 32'h40000000;
	// ************************************************************
	// other reset values
	// ************************************************************
	localparam logic [31:0] PC_RESET = 32'hA0000000;
	localparam logic [31:0] VBR_RESET = 32'h00000000;
	localparam logic [7:0] DSR_RESET = 8'h00;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	// ************************************************************
	// control-port indices
	// ************************************************************
	localparam logic [4:0] CR_SR = 5'h00;
	localparam logic [4:0] CR_SSR = 5'h01;
	localparam logic [4:0] CR_SPC = 5'h02;
	localparam logic [4:0] CR_GBR = 5'h03;
	localparam logic [4:0] CR_VBR = 5'h04;
	localparam logic [4:0] CR_RS = 5'h05;
	localparam logic [4:0] CR_RE = 5'h06;
	localparam logic [4:0] CR_MOD = 5'h07;
	localparam logic [4:0] CR_MULTIPLY_ACC_HIGH = 5'h08;
	localparam logic [4:0] CR_MULTIPLY_ACC_LOW = 5'h09;
	localparam logic [4:0] CR_PR = 5'h0A;
	localparam logic [4:0] CR_PC = 5'h0B;
	localparam logic [4:0] CR_DSR = 5'h0C;
	localparam logic [4:0] CR_A0 = 5'h0D;
	localparam logic [4:0] CR_X0 = 5'h0E;
	localparam logic [4:0] CR_X1 = 5'h0F;
	localparam logic [4:0] CR_Y0 = 5'h10;
	localparam logic [4:0] CR_Y1 = 5'h11;
	localparam logic [1:0] CR_ALT_TAG = 2'h3;
	// ************************************************************
	// address generation
	// ************************************************************
	localparam logic [3:0] R_IX = 4'h8;
	localparam logic [3:0] R_IY = 4'h9;
	localparam logic [3:0] R_AX0 = 4'h4;
	localparam logic [3:0] R_AY0 = 4'h6;
	localparam logic [3:0] R_AS0 = 4'h2;
	localparam logic [31:0] AG_STEP = 32'h00000002;
	localparam logic [31:0] CTL_STEP = 32'h00000004;
	localparam logic [1:0] RF_ONE = 2'h0;
	localparam logic [1:0] RF_TWO = 2'h1;
	localparam logic [1:0] RF_THREE = 2'h3;
	localparam logic [1:0] RF_MORE = 2'h2;
endpackage

// [sim/pipe_model.sv]
// pipeline-side model for the cpu register file: owns every request input
// and offers one task per kind of transfer. assumes a single core clock.
`timescale 1ns/1ns
`default_nettype none
module pipe_model
(
	input wire logic clk_sys,
	input wire logic [31:0] rd_a_q,
	input wire logic [31:0] rd_b_q,
	input wire logic [31:0] cr_rdata_q,
	output logic [3:0] rd_a_addr,
	output logic [3:0] rd_b_addr,
	output logic gw_en,
	output logic [3:0] gw_addr,
	output logic [31:0] gw_data,
	output logic [4:0] cr_addr,
	output logic [31:0] cr_wdata,
	output logic cr_wr,
	output logic cr_rd,
	output logic pc_we,
	output logic [31:0] pc_wdata,
	output logic exc_en,
	output logic repeat_setup_instr_en,
	output logic [11:0] repeat_setup_instr_count,
	output logic [2:0] repeat_setup_instr_len,
	output logic rc_dec,
	output logic loop_start_set_instr_en,
	output logic loop_end_set_instr_en,
	output logic [7:0] loop_disp,
	output logic mp_en,
	output logic mp_dec,
	output logic [3:0] mp_reg,
	output logic agx_en,
	output logic agx_sel,
	output logic agx_idx,
	output logic agy_en,
	output logic agy_sel,
	output logic agy_idx,
	output logic ags_en,
	output logic [1:0] ags_sel,
	output logic ags_idx
);
	// ************************************************************
	// requests, one-cycle strobes launched just after an edge
	// ************************************************************
	initial
	begin
		{rd_a_addr, rd_b_addr, gw_en, gw_addr, gw_data, cr_addr, cr_wdata, cr_wr, cr_rd} = '0;
		{pc_we, pc_wdata, exc_en, repeat_setup_instr_en, repeat_setup_instr_count, repeat_setup_instr_len, rc_dec, loop_start_set_instr_en, loop_end_set_instr_en, loop_disp} = '0;
		{mp_en, mp_dec, mp_reg, agx_en, agx_sel, agx_idx, agy_en, agy_sel, agy_idx, ags_en, ags_sel, ags_idx} = '0;
	end
	task automatic cr_write(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		cr_addr <= a;
		cr_wdata <= v;
		cr_wr <= 1'b1;
		@(posedge clk_sys);
		cr_wr <= 1'b0;
	endtask
	task automatic cr_read(input logic [4:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		cr_addr <= a;
		cr_rd <= 1'b1;
		@(posedge clk_sys);
		cr_rd <= 1'b0;
		#1;
		v = cr_rdata_q;
	endtask
	task automatic gp_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		gw_addr <= a;
		gw_data <= v;
		gw_en <= 1'b1;
		@(posedge clk_sys);
		gw_en <= 1'b0;
	endtask
	task automatic gp_read(input logic [3:0] a, output logic [31:0] v, output logic [31:0] w);
		@(posedge clk_sys);
		rd_a_addr <= a;
		rd_b_addr <= a;
		@(posedge clk_sys);
		#1;
		v = rd_a_q;
		w = rd_b_q;
	endtask
	// k: 0 counter load, 1 exception, 2 repeat setup, 3 repeat step, 4/5 loop start/end,
	// 6 control pointer, 7/8/9 x/y/single address; one shared field word keeps this short
	task automatic fire(input int k, input logic [31:0] v, input logic [3:0] r);
		@(posedge clk_sys);
		pc_wdata <= v;
		repeat_setup_instr_count <= v[11:0];
		repeat_setup_instr_len <= v[14:12];
		loop_disp <= v[7:0];
		mp_dec <= v[0];
		mp_reg <= r;
		agx_sel <= v[0];
		agy_sel <= v[0];
		ags_sel <= v[1:0];
		{agx_idx, agy_idx, ags_idx} <= {3{r[0]}};
		{ags_en, agy_en, agx_en, mp_en, loop_end_set_instr_en, loop_start_set_instr_en, rc_dec, repeat_setup_instr_en, exc_en, pc_we} <= 10'h001 << k;
		@(posedge clk_sys);
		{ags_en, agy_en, agx_en, mp_en, loop_end_set_instr_en, loop_start_set_instr_en, rc_dec, repeat_setup_instr_en, exc_en, pc_we} <= 10'h000;
		#1;
	endtask
endmodule
`default_nettype wire

// [sim/cpu_dsp_register_file_bench.sv]
// self-checking bench for the cpu register file: reset values, banking,
// pointer generation, repeat control, control pointers and exceptions.
// assumes pipe_model drives every pipeline-side input.
`timescale 1ns/1ns
`default_nettype none
module cpu_dsp_register_file_bench;
	logic clk_sys, rst, gw_en, cr_wr, cr_rd, pc_we, exc_en, repeat_setup_instr_en, rc_dec, loop_start_set_instr_en, loop_end_set_instr_en, mp_en, mp_dec;
	logic agx_en, agx_sel, agx_idx, agy_en, agy_sel, agy_idx, ags_en, ags_idx, dsp_mode;
	logic [3:0] rd_a_addr, rd_b_addr, gw_addr, mp_reg;
	logic [31:0] rd_a_q, rd_b_q, index_r0_q, gw_data, cr_wdata, cr_rdata_q, pc_wdata, pc_out;
	logic [31:0] mp_addr_q, x_addr_q, y_addr_q, s_addr_q, d, e;
	logic [4:0] cr_addr;
	logic [11:0] repeat_setup_instr_count, repeat_count;
	logic [2:0] repeat_setup_instr_len;
	logic [7:0] loop_disp;
	logic [1:0] ags_sel, repeat_steps;
	logic [2:0] lens [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	logic [1:0] codes [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2};
	logic [4:0] crs [10] = '{5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h03, 5'h08, 5'h09, 5'h0A};
	int fails = 0;
	int checks_done = 0;
	cpu_dsp_register_file cpu_dsp_register_file_i
	(
		.clk_sys, .rst, .rd_a_addr, .rd_b_addr, .rd_a_q, .rd_b_q, .index_r0_q, .gw_en, .gw_addr, .gw_data,
		.cr_addr, .cr_wdata, .cr_wr, .cr_rd, .cr_rdata_q, .pc_we, .pc_wdata, .pc_out, .exc_en, .repeat_setup_instr_en,
		.repeat_setup_instr_count, .repeat_setup_instr_len, .rc_dec, .loop_start_set_instr_en, .loop_end_set_instr_en, .loop_disp, .mp_en, .mp_dec, .mp_reg, .mp_addr_q,
		.agx_en, .agx_sel, .agx_idx, .x_addr_q, .agy_en, .agy_sel, .agy_idx, .y_addr_q, .ags_en, .ags_sel,
		.ags_idx, .s_addr_q, .dsp_mode, .repeat_count, .repeat_steps
	);
	pipe_model pipe_model_i
	(
		.clk_sys, .rd_a_q, .rd_b_q, .cr_rdata_q, .rd_a_addr, .rd_b_addr, .gw_en, .gw_addr, .gw_data, .cr_addr,
		.cr_wdata, .cr_wr, .cr_rd, .pc_we, .pc_wdata, .exc_en, .repeat_setup_instr_en, .repeat_setup_instr_count, .repeat_setup_instr_len, .rc_dec,
		.loop_start_set_instr_en, .loop_end_set_instr_en, .loop_disp, .mp_en, .mp_dec, .mp_reg, .agx_en, .agx_sel, .agx_idx, .agy_en,
		.agy_sel, .agy_idx, .ags_en, .ags_sel, .ags_idx
	);
	// ************************************************************
	// helpers
	// ************************************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string m);
		pipe_model_i.cr_read(a, d);
		chk(d, exp, m);
	endtask
	task automatic rdg(input logic [3:0] a, input logic [31:0] exp, input string m);
		pipe_model_i.gp_read(a, d, e);
		chk(d, exp, m);
		chk(e, exp, m);
	endtask
	task automatic wrc(input logic [4:0] a, input logic [31:0] v);
		pipe_model_i.cr_write(a, v);
	endtask
	task automatic wrg(input logic [3:0] a, input logic [31:0] v);
		pipe_model_i.gp_write(a, v);
	endtask
	task automatic go(input int k, input logic [31:0] v, input logic [3:0] r);
		pipe_model_i.fire(k, v, r);
	endtask
	task automatic test_done;
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial
	begin
		#100000;
		fails++;
		test_done();
	end
	// ************************************************************
	// sequence
	// ************************************************************
	initial
	begin
		rst = 1'b1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rdc(rf_pkg::CR_SR, 32'h700000F0, "sr reset");
		chk(pc_out, 32'hA0000000, "pc reset");
		rdc(rf_pkg::CR_VBR, 32'h00000000, "vbr reset");
		rdc(rf_pkg::CR_DSR, 32'h00000000, "dsr reset");
		chk({31'h0, dsp_mode}, 32'h00000000, "dsp off");
		wrc(rf_pkg::CR_SR, 32'hFFFFFFFF);
		rdc(rf_pkg::CR_SR, 32'h7FFF1FFF, "sr mask");
		chk({20'h0, repeat_count}, 32'h00000FFF, "rc field");
		chk({30'h0, repeat_steps}, 32'h00000003, "rf field");
		wrc(rf_pkg::CR_SR, 32'h20001000);
		wrg(4'h1, 32'hA1A1A1A1);
		wrc(rf_pkg::CR_SR, 32'h00001000);
		wrg(4'h1, 32'hB0B0B0B0);
		rdg(4'h1, 32'hB0B0B0B0, "bank0 view");
		rdc(5'h19, 32'hA1A1A1A1, "bank1 alt");
		wrc(rf_pkg::CR_SR, 32'h20001000);
		rdg(4'h1, 32'hA1A1A1A1, "bank1 view");
		chk({31'h0, dsp_mode}, 32'h00000001, "dsp on");
		rdc(5'h19, 32'hB0B0B0B0, "bank0 alt");
		wrg(4'h0, 32'h0000C0DE);
		rdg(4'h0, 32'h0000C0DE, "r0");
		chk(index_r0_q, 32'h0000C0DE, "r0 index");
		for (int i = 8; i < 16; i++)
			wrg(4'(i), {4'(i), 28'h5A5A5A5});
		for (int i = 8; i < 16; i++)
			rdg(4'(i), {4'(i), 28'h5A5A5A5}, "gpr");
		wrg(4'h4, 32'h00001000);
		wrg(4'h8, 32'h00000010);
		wrg(4'h6, 32'h00002000);
		wrg(4'h9, 32'h00000020);
		wrg(4'h2, 32'h00003000);
		wrg(4'h5, 32'h00005000);
		go(7, 32'h0, 4'h0);
		chk(x_addr_q, 32'h00001000, "x addr");
		go(7, 32'h0, 4'h1);
		chk(x_addr_q, 32'h00001002, "x step");
		rdg(4'h4, 32'h00001012, "x index");
		go(7, 32'h1, 4'h0);
		chk(x_addr_q, 32'h00005000, "x second");
		go(8, 32'h0, 4'h1);
		chk(y_addr_q, 32'h00002000, "y addr");
		rdg(4'h6, 32'h00002020, "y index");
		go(9, 32'h0, 4'h1);
		chk(s_addr_q, 32'h00003000, "s addr");
		rdg(4'h2, 32'h00003010, "s index");
		wrc(rf_pkg::CR_MOD, 32'h10041000);
		rdc(rf_pkg::CR_MOD, 32'h10041000, "bounds");
		wrc(rf_pkg::CR_SR, 32'h20001400);
		wrg(4'h4, 32'h00011004);
		wrg(4'h6, 32'h00011004);
		wrg(4'h2, 32'h00011004);
		go(7, 32'h0, 4'h0);
		go(8, 32'h0, 4'h0);
		go(9, 32'h0, 4'h0);
		rdg(4'h4, 32'h00011000, "x wrap");
		rdg(4'h6, 32'h00011006, "y no wrap");
		rdg(4'h2, 32'h00011006, "s no wrap");
		wrc(rf_pkg::CR_SR, 32'h20001C00);
		wrg(4'h4, 32'h00001004);
		wrg(4'h6, 32'h00001004);
		go(7, 32'h0, 4'h0);
		go(8, 32'h0, 4'h0);
		rdg(4'h4, 32'h00001006, "x both");
		rdg(4'h6, 32'h00001000, "y both");
		wrc(rf_pkg::CR_SR, 32'h20000000);
		go(7, 32'h0, 4'h0);
		rdg(4'h4, 32'h00001006, "dsp off gen");
		for (int i = 0; i < 5; i++)
		begin
			go(2, {17'h0, lens[i], 12'(i + 5)}, 4'h0);
			chk({30'h0, repeat_steps}, {30'h0, codes[i]}, "step code");
			chk({20'h0, repeat_count}, 32'(i + 5), "count");
		end
		go(3, 32'h0, 4'h0);
		chk({20'h0, repeat_count}, 32'h00000008, "count step");
		go(0, 32'h00000100, 4'h0);
		go(4, 32'h00000010, 4'h0);
		go(5, 32'h000000FE, 4'h0);
		rdc(rf_pkg::CR_RS, 32'h00000120, "loop start");
		rdc(rf_pkg::CR_RE, 32'h000000FC, "loop end");
		wrg(4'hA, 32'h00000200);
		go(6, 32'h0, 4'hA);
		chk(mp_addr_q, 32'h00000200, "post inc");
		rdg(4'hA, 32'h00000204, "post inc reg");
		go(6, 32'h1, 4'hA);
		chk(mp_addr_q, 32'h00000200, "pre dec");
		rdg(4'hA, 32'h00000200, "pre dec reg");
		go(1, 32'h0, 4'h0);
		rdc(rf_pkg::CR_SSR, 32'h60080008, "saved sr");
		rdc(rf_pkg::CR_SPC, 32'h00000100, "saved pc");
		for (int i = 0; i < 10; i++)
		begin
			wrc(crs[i], 32'hC3A55AF0 ^ 32'(crs[i]));
			rdc(crs[i], (i == 0) ? 32'h000000FC : 32'hC3A55AF0 ^ 32'(crs[i]), "sysreg");
		end
		wrc(5'h12, 32'hFFFFFFFF);
		rdc(5'h12, 32'h00000000, "unmapped");
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rdc(rf_pkg::CR_SR, 32'h700000F0, "sr rereset");
		chk(pc_out, 32'hA0000000, "pc rereset");
		test_done();
	end
endmodule
`default_nettype wire
